// ---- rtl/acs_pkg.sv ----
package acs_pkg;
    // register byte offsets on the ahb-lite slave
    localparam logic [7:0] ACS_OFF_CTRL = 8'h00;
    localparam logic [7:0] ACS_OFF_CLKSEL = 8'h04;
    localparam logic [7:0] ACS_OFF_RESULT = 8'h08;
    localparam logic [7:0] ACS_OFF_STATUS = 8'h0c;
    localparam logic [7:0] ACS_OFF_COMPARE = 8'h10;
    localparam logic [7:0] ACS_OFF_PINCFG = 8'h14;
    localparam logic [7:0] ACS_OFF_PORT = 8'h18;
    // control register fields
    localparam int ACS_CTRL_ON_BIT = 0;
    localparam int ACS_CTRL_GO_BIT = 1;
    localparam int ACS_CTRL_CHAN_LSB = 2;
    // status register fields
    localparam int ACS_STAT_DONE_BIT = 0;
    localparam int ACS_STAT_BUSY_BIT = 1;
    // widths and reset values
    localparam int ACS_NPINS = 16;
    localparam int ACS_RES_W = 10;
    localparam logic [3:0] ACS_MODE_TRIGGER = 4'hb;
    localparam logic [2:0] ACS_CLKSEL_RESET = 3'h0;
    localparam logic [15:0] ACS_DIR_RESET = 16'hffff;
    localparam logic [9:0] ACS_RESULT_RESET = 10'h000;
    // conversion timing in bit periods
    localparam logic [3:0] ACS_CONV_TADS = 4'hc;
    localparam logic [3:0] ACS_GAP_TADS = 4'h2;
    // oscillator rate and minimum bit period
    localparam int ACS_CLK_MHZ = 50;
    localparam int ACS_MIN_TAD_NS = 1600;
    localparam int ACS_CLK_NS = 1000 / ACS_CLK_MHZ;
    localparam int ACS_MIN_TAD_CYC = (ACS_MIN_TAD_NS + ACS_CLK_NS - 1) / ACS_CLK_NS;

    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_CONV = 2'b01,
        ACS_GAP = 2'b10
    } acs_state_t;

    // pin-side signals kept together
    typedef struct packed {
        logic [ACS_NPINS-1:0] analog_en;
        logic [ACS_NPINS-1:0] pin_direction_bits;
        logic [ACS_NPINS-1:0] pin_level;
    } acs_pins_t;

    typedef struct packed {
        logic sample_hold;
        logic compare_bit;
        logic [3:0] bit_index;
    } acs_sampler_t;
endpackage

// ---- rtl/acs_tick_gen.sv ----
`timescale 1ns/1ps
// bit-period tick source: divided oscillator or synchronised rc clock
module acs_tick_gen (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic enable,
    input wire logic [2:0] conv_clock_select,
    // internal rc oscillator level, resampled to clk by the two-stage synchroniser here
    input wire logic rc_clock,
    // tick out
    output logic tick
);
    import acs_pkg::*;

    logic [5:0] count;
    logic [5:0] limit;
    logic rc_sync1;
    logic rc_sync2;
    logic rc_last;
    logic use_rc;

    // divide ratio minus one from the select code
    always_comb begin
        unique case (conv_clock_select)
            3'h0: limit = 6'h01;
            3'h4: limit = 6'h03;
            3'h1: limit = 6'h07;
            3'h5: limit = 6'h0f;
            3'h2: limit = 6'h1f;
            3'h6: limit = 6'h3f;
            default: limit = 6'h3f;
        endcase
    end

    assign use_rc = (conv_clock_select[1:0] == 2'h3);

    // two-stage synchroniser; the edge detect looks only at the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rc_sync1 <= 1'b0;
            rc_sync2 <= 1'b0;
            rc_last <= 1'b0;
        end else begin
            rc_sync1 <= rc_clock;
            rc_sync2 <= rc_sync1;
            rc_last <= rc_sync2;
        end
    end

    // counter restarts while disabled so every period starts whole
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= 6'h00;
            tick <= 1'b0;
        end else if (!enable) begin
            count <= 6'h00;
            tick <= 1'b0;
        end else if (use_rc) begin
            count <= 6'h00;
            tick <= rc_sync2 & ~rc_last;
        end else if (count >= limit) begin
            count <= 6'h00;
            tick <= 1'b1;
        end else begin
            count <= count + 6'h01;
            tick <= 1'b0;
        end
    end
endmodule

// ---- rtl/acs_sequencer.sv ----
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module acs_sequencer (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // compare unit two trigger
    input wire logic compare_event,
    output logic timer_reset,
    // internal rc oscillator
    input wire logic rc_clock,
    // port pins
    input wire acs_pkg::acs_pins_t pins,
    // analog sampler
    input wire logic comparator_out,
    output acs_pkg::acs_sampler_t sampler,
    output logic [3:0] mux_channel,
    output logic acquire,
    // status levels
    output logic conv_done_flag,
    output logic busy
);
    import acs_pkg::*;

    logic converter_on;
    logic go;
    logic [3:0] channel_select;
    logic [2:0] conv_clock_select;
    logic [3:0] compare2_mode_field;
    logic [ACS_NPINS-1:0] analog_pin_config;
    logic [ACS_RES_W-1:0] result;
    logic [ACS_RES_W-1:0] sar;
    logic [3:0] tad_count;
    acs_state_t state;
    logic tick;
    logic trig_ok;
    logic [7:0] dp_addr;
    logic dp_write;
    logic dp_read;
    logic go_clear_sw;
    logic go_set_sw;
    logic conv_end;
    logic abort;

    ////////////////////////////////////////////////////////////////
    // bus address phase capture

    // only whole-word writes are mapped, reads of any size are answered; the slave never waits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dp_addr <= 8'h00;
            dp_write <= 1'b0;
            dp_read <= 1'b0;
        end else if (hready) begin
            dp_addr <= haddr[7:0];
            dp_write <= hsel & htrans[1] & hwrite & (hsize == 3'h2);
            dp_read <= hsel & htrans[1] & ~hwrite;
        end else begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
        end
    end

    // zero-wait responses, always okay
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    function automatic logic is_wr(input logic [7:0] a, input logic [7:0] off, input logic w);
        is_wr = w && (a == off);
    endfunction

    ////////////////////////////////////////////////////////////////
    // conversion control

    assign go_clear_sw = is_wr(dp_addr, ACS_OFF_CTRL, dp_write) && !hwdata[ACS_CTRL_GO_BIT];
    // set go only when converter already on, before this write
    assign go_set_sw = is_wr(dp_addr, ACS_OFF_CTRL, dp_write) && hwdata[ACS_CTRL_GO_BIT]
        && converter_on;
    assign trig_ok = compare_event && converter_on
        && (compare2_mode_field == ACS_MODE_TRIGGER);
    assign conv_end = (state == ACS_CONV) && tick && (tad_count == ACS_CONV_TADS - 4'h1);
    assign abort = (state == ACS_CONV) && (go_clear_sw || !converter_on);

    // timer reset follows every trigger while the compare mode is ACS_MODE_TRIGGER, regardless of converter state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timer_reset <= 1'b0;
        end else begin
            timer_reset <= compare_event && (compare2_mode_field == ACS_MODE_TRIGGER);
        end
    end

    // control register; hardware trigger set wins over a software clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            converter_on <= 1'b0;
            channel_select <= 4'h0;
        end else if (is_wr(dp_addr, ACS_OFF_CTRL, dp_write)) begin
            converter_on <= hwdata[ACS_CTRL_ON_BIT];
            channel_select <= hwdata[ACS_CTRL_CHAN_LSB +: 4];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            go <= 1'b0;
        end else if (trig_ok || go_set_sw) begin
            go <= 1'b1;
        end else if (conv_end || go_clear_sw || !converter_on) begin
            go <= 1'b0;
        end
    end

    // configuration registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_clock_select <= ACS_CLKSEL_RESET;
            compare2_mode_field <= 4'h0;
            analog_pin_config <= 16'h0000;
        end else begin
            if (is_wr(dp_addr, ACS_OFF_CLKSEL, dp_write)) begin
                conv_clock_select <= hwdata[2:0];
            end
            if (is_wr(dp_addr, ACS_OFF_COMPARE, dp_write)) begin
                compare2_mode_field <= hwdata[3:0];
            end
            if (is_wr(dp_addr, ACS_OFF_PINCFG, dp_write)) begin
                analog_pin_config <= hwdata[15:0];
            end
        end
    end

    acs_tick_gen u_tick (
        .clk(clk),
        .rst(rst),
        // an abort restarts the divider so on the divided settings the gap is two whole bit periods
        .enable(converter_on && !abort),
        .conv_clock_select(conv_clock_select),
        .rc_clock(rc_clock),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////
    // sequencer state

    // channel and pin direction never enter this machine
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ACS_IDLE;
            tad_count <= 4'h0;
        end else if (!converter_on) begin
            state <= ACS_IDLE;
            tad_count <= 4'h0;
        end else begin
            unique case (state)
                ACS_IDLE: begin
                    if (go && tick) begin
                        state <= ACS_CONV;
                        tad_count <= 4'h0;
                    end
                end
                ACS_CONV: begin
                    if (abort || conv_end) begin
                        state <= ACS_GAP;
                        tad_count <= 4'h0;
                    end else if (tick) begin
                        tad_count <= tad_count + 4'h1;
                    end
                end
                ACS_GAP: begin
                    if (tick && tad_count == ACS_GAP_TADS - 4'h1) begin
                        state <= ACS_IDLE;
                        tad_count <= 4'h0;
                    end else if (tick) begin
                        tad_count <= tad_count + 4'h1;
                    end
                end
                default: begin
                    state <= ACS_IDLE;
                end
            endcase
        end
    end

    // successive approximation: bit 9 at period 1 down to bit 0 at period 10
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sar <= 10'h000;
        end else if (state == ACS_IDLE) begin
            sar <= 10'h000;
        end else if (state == ACS_CONV && tick && tad_count >= 4'h1 && tad_count <= 4'ha) begin
            sar[4'ha - tad_count] <= comparator_out;
        end
    end

    // result loads from the conversion only on full completion, or from a bus write; an abort leaves it alone
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            result <= ACS_RESULT_RESET;
        end else if (conv_end && !abort) begin
            result <= sar;
        end else if (is_wr(dp_addr, ACS_OFF_RESULT, dp_write)) begin
            result <= hwdata[ACS_RES_W-1:0];
        end
    end

    // done flag: completion set wins over software clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_done_flag <= 1'b0;
        end else if (conv_end && !abort) begin
            conv_done_flag <= 1'b1;
        end else if (is_wr(dp_addr, ACS_OFF_STATUS, dp_write)
            && hwdata[ACS_STAT_DONE_BIT]) begin
            conv_done_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // sampler outputs

    // port reads give zero for analog pins; driven outputs convert the same way
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sampler <= '0;
            mux_channel <= 4'h0;
            acquire <= 1'b0;
            busy <= 1'b0;
        end else begin
            sampler.sample_hold <= (state == ACS_CONV);
            sampler.compare_bit <= comparator_out;
            sampler.bit_index <= tad_count;
            mux_channel <= channel_select;
            acquire <= converter_on && (state == ACS_IDLE);
            busy <= (state == ACS_CONV);
        end
    end

    ////////////////////////////////////////////////////////////////
    // read data

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h00000000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            unique case (haddr[7:0])
                ACS_OFF_CTRL: hrdata <= {26'h0, channel_select, go, converter_on};
                ACS_OFF_CLKSEL: hrdata <= {29'h0, conv_clock_select};
                ACS_OFF_RESULT: hrdata <= {22'h0, result};
                ACS_OFF_STATUS: hrdata <= {30'h0, (state == ACS_CONV), conv_done_flag};
                ACS_OFF_COMPARE: hrdata <= {28'h0, compare2_mode_field};
                ACS_OFF_PINCFG: hrdata <= {16'h0, analog_pin_config};
                ACS_OFF_PORT: hrdata <= {16'h0, pins.pin_level & ~analog_pin_config};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end
endmodule

// ---- testbench/acs_sequencer_sva.sv ----
`timescale 1ns/1ps
module acs_sequencer_sva (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // watched signals
    input wire logic compare_event,
    input wire logic timer_reset,
    input wire acs_pkg::acs_sampler_t sampler,
    input wire logic conv_done_flag,
    input wire logic busy,
    input wire logic acquire
);
    import acs_pkg::*;
    // one domain, so clock and reset are given once
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    property p_no_overlap;
        !(busy && acquire);
    endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("acquire raised during a conversion");
    property p_gap;
        $fell(busy) |-> !acquire [*2];
    endproperty
    a_gap: assert property (p_gap)
        else $error("acquire came back without a gap");
    // bound the wait: slowest gap is two ticks of the rc oscillator setting, 80 clocks each
    property p_reacquire;
        $fell(busy) |-> ##[2:300] acquire;
    endproperty
    a_reacquire: assert property (p_reacquire)
        else $error("acquire did not restart after the gap");
    property p_done_end;
        $rose(conv_done_flag) |-> ##1 $fell(busy);
    endproperty
    a_done_end: assert property (p_done_end)
        else $error("done flag rose outside the end of a conversion");
    property p_hold_start;
        $rose(busy) |-> sampler.sample_hold;
    endproperty
    a_hold_start: assert property (p_hold_start)
        else $error("hold capacitor not disconnected at conversion start");
    property p_hold_idle;
        !busy |-> !sampler.sample_hold;
    endproperty
    a_hold_idle: assert property (p_hold_idle)
        else $error("hold capacitor disconnected while idle");
    property p_conv_len;
        $rose(busy) |-> ##[1:1000] !busy;
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion ran past twelve of the slowest bit periods");
    property p_conv_min;
        $rose(busy) |-> busy [*4];
    endproperty
    a_conv_min: assert property (p_conv_min)
        else $error("conversion far too short");
    property p_timer;
        timer_reset |-> $past(compare_event);
    endproperty
    a_timer: assert property (p_timer)
        else $error("timer reset without a trigger");
    // main scenarios reached
    c_conv: cover property ($rose(busy));
    c_done: cover property ($rose(conv_done_flag));
    c_timer: cover property (timer_reset);
    c_acq: cover property ($rose(acquire));
endmodule
bind acs_sequencer acs_sequencer_sva i_acs_sequencer_sva (
    .clk(clk), .rst(rst), .compare_event(compare_event), .timer_reset(timer_reset),
    .sampler(sampler), .conv_done_flag(conv_done_flag), .busy(busy), .acquire(acquire)
);

// ---- testbench/tb_acs_sequencer.sv ----
`timescale 1ns/1ps
module tb_acs_sequencer;
    import acs_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic compare_event = 1'b0;
    logic timer_reset;
    logic rc_clock = 1'b0;
    logic cmp_in = 1'b1;
    acs_pins_t pins = '0;
    acs_sampler_t sampler;
    logic [3:0] mux_channel;
    logic acquire;
    logic conv_done_flag;
    logic busy;
    int err_count = 0;
    int samples_checked = 0;
    int n;
    int rc_cnt = 0;
    logic [31:0] rd;
    logic [2:0] sels [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    int tads [8] = '{2, 4, 8, 16, 32, 64, ACS_MIN_TAD_CYC, ACS_MIN_TAD_CYC};
    ////////////////////////////////////////////////////////////////////////
    acs_sequencer i_acs_sequencer (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .compare_event(compare_event), .timer_reset(timer_reset), .rc_clock(rc_clock),
        .pins(pins), .comparator_out(cmp_in), .sampler(sampler), .mux_channel(mux_channel),
        .acquire(acquire), .conv_done_flag(conv_done_flag), .busy(busy)
    );
    // clock; rc period is the minimum bit period in clocks, so its ticks are exact
    always #10 clk = ~clk;
    always @(posedge clk) begin
        rc_cnt <= (rc_cnt + 1) % (ACS_MIN_TAD_CYC / 2);
        if (rc_cnt == ACS_MIN_TAD_CYC / 2 - 1) rc_clock <= ~rc_clock;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one single ahb-lite transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    // n counts cycles until busy (0) or acquire (1) reaches v
    task automatic wait_sig(input int which, input logic v);
        n = 0;
        while (((which != 0) ? acquire : busy) !== v && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    task automatic pulse;
        @(posedge clk);
        compare_event <= 1'b1;
        @(posedge clk);
        compare_event <= 1'b0;
        #1;
        rd = {31'h0, timer_reset};
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // watchdog: whole sequence needs well under ten thousand cycles
    initial begin
        repeat (30000) @(posedge clk);
        err_count++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({hresp, hreadyout, busy, acquire, conv_done_flag}, 32'h8);
        bus(0, ACS_OFF_CTRL, 0);
        chk(rd, 32'h0);
        bus(0, ACS_OFF_RESULT, 0);
        chk(rd, {22'h0, ACS_RESULT_RESET});
        bus(0, 8'h40, 0);
        chk(rd, 32'h0);
        // go in the same write as switching on is refused
        bus(1, ACS_OFF_CTRL, 32'h7);
        repeat (20) @(posedge clk);
        bus(0, ACS_OFF_STATUS, 0);
        chk(rd, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            pins.pin_direction_bits <= {16{i[0]}};
            cmp_in <= i[1];
            bus(1, ACS_OFF_CLKSEL, {29'h0, sels[i]});
            bus(1, ACS_OFF_CTRL, 32'h7);
            wait_sig(0, 1'b1);
            wait_sig(0, 1'b0);
            chk(n, 12 * tads[i]);
            wait_sig(1, 1'b1);
            chk({31'h0, n >= 2 * tads[i] && n <= 2 * tads[i] + 3}, 32'h1);
            bus(0, ACS_OFF_STATUS, 0);
            chk(rd, 32'h1);
            bus(0, ACS_OFF_CTRL, 0);
            chk(rd, 32'h5);
            bus(0, ACS_OFF_RESULT, 0);
            chk(rd, {22'h0, {10{i[1]}}});
            bus(1, ACS_OFF_STATUS, 32'h1);
        end
        $display("test clock select done");
        // abort about fifty cycles into a slow conversion
        bus(1, ACS_OFF_CLKSEL, 32'h6);
        bus(1, ACS_OFF_RESULT, 32'h155);
        bus(1, ACS_OFF_CTRL, 32'h7);
        wait_sig(0, 1'b1);
        repeat (50) @(posedge clk);
        bus(1, ACS_OFF_CTRL, 32'h5);
        wait_sig(0, 1'b0);
        chk({31'h0, n <= 3}, 32'h1);
        wait_sig(1, 1'b1);
        chk({31'h0, n >= 128 && n <= 131}, 32'h1);
        bus(0, ACS_OFF_RESULT, 0);
        chk(rd, 32'h155);
        bus(0, ACS_OFF_STATUS, 0);
        chk(rd, 32'h0);
        $display("test abort done");
        // trigger while on, while off, and in a wrong mode
        bus(1, ACS_OFF_COMPARE, {28'h0, ACS_MODE_TRIGGER});
        pulse();
        chk(rd, 32'h1);
        wait_sig(0, 1'b1);
        wait_sig(0, 1'b0);
        chk(n, 768);
        wait_sig(1, 1'b1);
        bus(1, ACS_OFF_CTRL, 32'h0);
        pulse();
        chk(rd, 32'h1);
        repeat (300) @(posedge clk);
        chk({31'h0, busy}, 32'h0);
        bus(1, ACS_OFF_COMPARE, 32'ha);
        pulse();
        chk(rd, 32'h0);
        $display("test trigger done");
        bus(1, ACS_OFF_PINCFG, 32'h00ff);
        pins.pin_level <= 16'hffff;
        bus(0, ACS_OFF_PORT, 0);
        chk(rd, 32'hff00);
        $display("test port done");
        close_out();
    end
endmodule
